/* File: design/program_counter_stack_indirect.sv */
// What this block does
// - Program counter is thirteen bits wide.
// - Low counter byte is readable and writable.
// - Software writes upper bits only through high latch.
// - Reset clears the whole program counter.
// - Low byte write loads upper five bits.
// - Call or jump takes latch bits four, three.
// - Eight entry, thirteen bit return stack.
// - Stack and its pointer invisible to software.
// - Call pushes counter plus one; interrupt vector pushes counter.
// - Returns of any kind pop the stack.
// - Push and pop leave high latch alone.
// - Stack wraps; ninth push overwrites first.
// - No overflow or underflow indication exists.
// - Indirect register redirects through the pointer.
// - Indirect read of itself returns zero.
// - Indirect write of itself stores nothing.
// - Address is bank bit above pointer.
`timescale 1ns/1ps
module program_counter_stack_indirect
  import pcstack_pkg::*;
#(
  parameter logic [PC_W-1:0] VECTOR_ADDR = VECTOR_DEFAULT
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus, AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Program flow strobes from the sequencer.
  input wire logic flow_step,
  input wire logic flow_jump,
  input wire logic flow_call,
  input wire logic flow_return,
  input wire logic flow_vector,
  input wire logic [FIELD_W-1:0] flow_target,
  // Program counter to the fetch logic.
  output logic [PC_W-1:0] pc,
  // Data access request from the sequencer.
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [DATA_AW-1:0] acc_addr,
  input wire logic [LOW_W-1:0] acc_wdata,
  // Data memory side.
  output logic [DATA_AW-1:0] data_addr,
  output logic data_rd,
  output logic data_wr,
  output logic [LOW_W-1:0] data_wdata,
  input wire logic [LOW_W-1:0] mem_rdata,
  // Data access answer.
  output logic [LOW_W-1:0] acc_rdata,
  output logic acc_rdata_valid
);

  import pcstack_pkg::*;

  // Program counter and its software-visible neighbours.
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [LATCH_W-1:0] latch_r;
  logic [PTR_W-1:0] pointer_r;
  logic bank_r;
  logic [DATA_AW-1:0] eff_last_r;

  // Stack control.
  logic push_en;
  logic pop_en;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] pop_val;

  // Bus slave state.
  bus_state_t bus_state_r;
  logic [REG_AW-1:0] addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic addr_phase;
  logic wr_fire;
  logic [LOW_W-1:0] bus_byte;
  logic low_wr;
  logic [31:0] read_mux;

  // Data path state.
  logic [DATA_AW-1:0] eff_addr;
  logic self_ref;
  logic [DATA_AW-1:0] data_addr_r;
  logic data_rd_r;
  logic data_wr_r;
  logic [LOW_W-1:0] data_wdata_r;
  logic rd_stage_r;
  logic self_stage_r;
  logic [LOW_W-1:0] acc_rdata_r;
  logic acc_rdata_valid_r;

  // Return stack holding full counter values.
  pc_return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(push_en),
    .pop(pop_en),
    .push_data(push_val),
    .top_data(pop_val)
  );

  // Resolver for the indirect data address.
  indirect_resolve u_resolve (
    .req_addr(acc_addr),
    .pointer(pointer_r),
    .bank_bit(bank_r),
    .eff_addr(eff_addr),
    .self_ref(self_ref)
  );

  // Bus decode: a transfer is taken when selected, active and ready.
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_fire = (bus_state_r == BUS_WRITE);
  assign bus_byte = hwdata[LOW_W-1:0];
  assign low_wr = wr_fire && (addr_r == OFF_COUNTER_LOW);

  // Next counter value; flow strobes outrank a bus write of the low byte,
  // which in turn replaces the plain increment as a computed jump.
  always_comb
  begin
    pc_nxt = pc_r;
    push_en = 1'b0;
    pop_en = 1'b0;
    push_val = pc_r;
    if (flow_vector)
    begin
      pc_nxt = VECTOR_ADDR;
      push_en = 1'b1;
      push_val = pc_r;
    end
    else if (flow_call)
    begin
      pc_nxt = {latch_r[4:3], flow_target};
      push_en = 1'b1;
      push_val = pc_r + PC_ONE;
    end
    else if (flow_jump)
    begin
      pc_nxt = {latch_r[4:3], flow_target};
    end
    else if (flow_return)
    begin
      pc_nxt = pop_val;
      pop_en = 1'b1;
    end
    else if (low_wr)
    begin
      pc_nxt = {latch_r, bus_byte};
    end
    else if (flow_step)
    begin
      pc_nxt = pc_r + PC_ONE;
    end
  end

  // Counter register, cleared by reset.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pc_r <= PC_RESET;
    else
      pc_r <= pc_nxt;
  end

  // High latch changes only by a bus write, never by the stack.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latch_r <= LATCH_RESET;
    else if (wr_fire && (addr_r == OFF_HIGH_LATCH))
      latch_r <= hwdata[LATCH_W-1:0];
  end

  // Pointer register for indirect access.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pointer_r <= POINTER_RESET;
    else if (wr_fire && (addr_r == OFF_POINTER))
      pointer_r <= bus_byte;
  end

  // Bank bit held at bit seven of the status word.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bank_r <= 1'b0;
    else if (wr_fire && (addr_r == OFF_STATUS))
      bank_r <= hwdata[BANK_BIT_POS];
  end

  // Read view of the registers; upper counter bits are never shown.
  always_comb
  begin
    read_mux = RDATA_ZERO;
    case (addr_r)
      OFF_COUNTER_LOW: read_mux[LOW_W-1:0] = pc_r[LOW_W-1:0];
      OFF_HIGH_LATCH: read_mux[LATCH_W-1:0] = latch_r;
      OFF_POINTER: read_mux[PTR_W-1:0] = pointer_r;
      OFF_STATUS: read_mux[BANK_BIT_POS] = bank_r;
      OFF_EFF_ADDR: read_mux[DATA_AW-1:0] = eff_last_r;
      default: read_mux = RDATA_ZERO;
    endcase
  end

  // Bus slave: writes finish with no wait, reads take one wait state so
  // a read right after a write sees the written value.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state_r <= BUS_IDLE;
      addr_r <= '0;
      hrdata_r <= RDATA_ZERO;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      case (bus_state_r)
        BUS_READ:
        begin
          hrdata_r <= read_mux;
          hreadyout_r <= 1'b1;
          bus_state_r <= BUS_IDLE;
        end
        BUS_IDLE, BUS_WRITE:
        begin
          if (addr_phase)
          begin
            addr_r <= haddr[REG_AW-1:0];
            hreadyout_r <= hwrite;
            bus_state_r <= hwrite ? BUS_WRITE : BUS_READ;
          end
          else
          begin
            bus_state_r <= BUS_IDLE;
          end
        end
        default:
        begin
          hreadyout_r <= 1'b1;
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // Response is always OKAY; unmapped offsets read zero.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp_r <= HRESP_OKAY;
    else
      hresp_r <= HRESP_OKAY;
  end

  // Last resolved data address, kept for software to inspect.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      eff_last_r <= EFF_RESET;
    else if (acc_valid)
      eff_last_r <= eff_addr;
  end

  // Memory strobes; a self-referencing access touches no storage.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_addr_r <= EFF_RESET;
      data_rd_r <= 1'b0;
      data_wr_r <= 1'b0;
      data_wdata_r <= READ_ZERO;
    end
    else
    begin
      data_rd_r <= acc_valid && !acc_write && !self_ref;
      data_wr_r <= acc_valid && acc_write && !self_ref;
      if (acc_valid)
      begin
        data_addr_r <= eff_addr;
        data_wdata_r <= acc_wdata;
      end
    end
  end

  // Read answer one cycle after the memory strobe.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_stage_r <= 1'b0;
      self_stage_r <= 1'b0;
      acc_rdata_r <= READ_ZERO;
      acc_rdata_valid_r <= 1'b0;
    end
    else
    begin
      rd_stage_r <= acc_valid && !acc_write;
      self_stage_r <= self_ref;
      acc_rdata_valid_r <= rd_stage_r;
      if (rd_stage_r)
        acc_rdata_r <= self_stage_r ? READ_ZERO : mem_rdata;
    end
  end

  // Outputs straight from flip-flops.
  assign pc = pc_r;
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign data_addr = data_addr_r;
  assign data_rd = data_rd_r;
  assign data_wr = data_wr_r;
  assign data_wdata = data_wdata_r;
  assign acc_rdata = acc_rdata_r;
  assign acc_rdata_valid = acc_rdata_valid_r;

endmodule

/* File: shared/pcstack_pkg.sv */
package pcstack_pkg;

  // Widths of the program counter and its parts.
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int FIELD_W = 11;
  localparam int STACK_DEPTH = 8;

  // Widths of the data addressing path.
  localparam int DATA_AW = 9;
  localparam int PTR_W = 8;
  localparam int DIRECT_W = 7;
  localparam int BANK_BIT_POS = 7;
  localparam logic [6:0] INDIRECT_ADDR = 7'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Register offsets on the bus, byte addresses of aligned words.
  localparam int REG_AW = 8;
  localparam logic [7:0] OFF_COUNTER_LOW = 8'h00;
  localparam logic [7:0] OFF_HIGH_LATCH = 8'h04;
  localparam logic [7:0] OFF_POINTER = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_EFF_ADDR = 8'h10;

  // Reset values, increment step and default vector.
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_ONE = 13'h0001;
  localparam logic [12:0] VECTOR_DEFAULT = 13'h0004;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [8:0] EFF_RESET = 9'h000;

  // Bus encodings.
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // Register bus slave states.
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_WRITE = 3'b100
  } bus_state_t;

endpackage

/* File: design/pc_return_stack.sv */
`timescale 1ns/1ps
module pc_return_stack
  import pcstack_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Stack operations.
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_ONE = 1;

  logic [WIDTH-1:0] entry_mem [DEPTH];
  logic [PW-1:0] ptr_r;

  // Most recently pushed entry sits one below the pointer.
  assign top_data = entry_mem[ptr_r - PTR_ONE];

  // Pointer wraps around, so a ninth push lands on the first slot.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ptr_r <= '0;
    else if (push)
      ptr_r <= ptr_r + PTR_ONE;
    else if (pop)
      ptr_r <= ptr_r - PTR_ONE;
  end

  // Storage has no address in any space and no overflow flag.
  always_ff @(posedge hclk)
  begin
    if (push)
      entry_mem[ptr_r] <= push_data;
  end

endmodule

/* File: design/indirect_resolve.sv */
`timescale 1ns/1ps
module indirect_resolve
  import pcstack_pkg::*;
(
  // Requested direct address and pointer state.
  input wire logic [DATA_AW-1:0] req_addr,
  input wire logic [PTR_W-1:0] pointer,
  input wire logic bank_bit,
  // Resolved location.
  output logic [DATA_AW-1:0] eff_addr,
  output logic self_ref
);

  logic hits_indirect;

  // The indirect register has no storage; it redirects to the pointer.
  assign hits_indirect = (req_addr[DIRECT_W-1:0] == INDIRECT_ADDR);

  // Bank bit sits above the pointer to form the 9-bit address.
  assign eff_addr = hits_indirect ? {bank_bit, pointer} : req_addr;

  // A pointer aimed back at the indirect register reaches nothing.
  assign self_ref = hits_indirect &&
                    (pointer[DIRECT_W-1:0] == INDIRECT_ADDR);

endmodule

/* File: test/data_mem_model.sv */
`timescale 1ns/1ps
module data_mem_model
  import pcstack_pkg::*;
(
  // Clock.
  input wire logic hclk,
  // Data memory side of the block.
  input wire logic [DATA_AW-1:0] data_addr,
  input wire logic data_rd,
  output logic [LOW_W-1:0] mem_rdata
);
  logic [LOW_W-1:0] last_r = 8'h00;

  // A read answers at once; between reads the line shows a changing pattern.
  assign mem_rdata = data_rd ?
    (data_addr[7:0] ^ {7'h00, data_addr[8]} ^ 8'h3c) : ~last_r;

  // Remembers the last value so idle cycles never repeat it.
  always_ff @(posedge hclk)
  begin
    last_r <= mem_rdata;
  end
endmodule

/* File: test/pcsi_checker.sv */
`timescale 1ns/1ps
module pcsi_checker
  import pcstack_pkg::*;
#(
  parameter logic [PC_W-1:0] VECTOR_ADDR = VECTOR_DEFAULT
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Program flow.
  input wire logic flow_jump,
  input wire logic flow_call,
  input wire logic flow_return,
  input wire logic flow_vector,
  input wire logic [FIELD_W-1:0] flow_target,
  input wire logic [PC_W-1:0] pc,
  // Data access.
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [DATA_AW-1:0] acc_addr,
  input wire logic [LOW_W-1:0] acc_wdata,
  input wire logic [DATA_AW-1:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [LOW_W-1:0] data_wdata,
  input wire logic [LOW_W-1:0] mem_rdata,
  input wire logic [LOW_W-1:0] acc_rdata,
  input wire logic acc_rdata_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Steps of a call followed at once by a return.
  sequence s_call;
    flow_call && !flow_vector;
  endsequence
  sequence s_ret;
    flow_return && !flow_vector && !flow_call && !flow_jump;
  endsequence

  // Relations between the flow strobes and the counter.
  property p_rst;
    $rose(hresetn) |-> pc == PC_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("pc not clear");
  property p_vec;
    flow_vector |=> pc == VECTOR_ADDR;
  endproperty
  a_vec: assert property (p_vec) else $error("pc not at vector");
  property p_jump;
    flow_jump && !flow_vector && !flow_call |=>
      pc[10:0] == $past(flow_target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump low bits");
  property p_ret;
    s_call ##1 s_ret |=> pc == $past(pc, 2) + 13'h0001;
  endproperty
  a_ret: assert property (p_ret) else $error("return address");

  // Bus read wait state.
  property p_rd;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait state");

  // Data accesses, direct and through the pointer.
  property p_acc;
    acc_valid && !acc_write && acc_addr[6:0] != 7'h00 |=>
      data_rd && data_addr == $past(acc_addr) ##1
      acc_rdata_valid && acc_rdata == $past(mem_rdata);
  endproperty
  a_acc: assert property (p_acc) else $error("direct read");
  property p_wr;
    acc_valid && acc_write && acc_addr[6:0] != 7'h00 |=>
      data_wr && data_wdata == $past(acc_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("direct write");
  property p_self;
    acc_valid && acc_addr[6:0] == 7'h00 |=>
      (data_rd || data_wr) == (data_addr[6:0] != 7'h00);
  endproperty
  a_self: assert property (p_self) else $error("self access");
  property p_zero;
    acc_valid && !acc_write && acc_addr[6:0] == 7'h00 ##1 !data_rd |=>
      acc_rdata_valid && acc_rdata == READ_ZERO;
  endproperty
  a_zero: assert property (p_zero) else $error("self read value");
endmodule

bind program_counter_stack_indirect pcsi_checker
  #(.VECTOR_ADDR(VECTOR_ADDR)) chk_u (.*);

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pcstack_pkg::*;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %h seen %h", n, e, g); end end
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] fl = 5'h00;
  logic [10:0] flow_target = 11'h000;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic [8:0] acc_addr = 9'h000;
  logic [7:0] acc_wdata = 8'h00;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic data_rd;
  logic data_wr;
  logic acc_rdata_valid;
  logic [12:0] pc;
  logic [8:0] data_addr;
  logic [7:0] data_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] acc_rdata;
  logic [31:0] rnd = 32'h0000004d;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int m_pc = 0;
  int lat = 0;
  int ptr = 0;
  int bank = 0;
  int sp = 0;
  int stk[8];

  program_counter_stack_indirect dut_u (.*, .hready(hreadyout),
    .flow_step(fl[0]), .flow_return(fl[1]), .flow_jump(fl[2]),
    .flow_call(fl[3]), .flow_vector(fl[4]));
  data_mem_model mem_u (.*);

  // Free running clock at 200 MHz.
  initial
  begin
    forever #2.5 hclk = ~hclk;
  end

  // Cuts a hung run short.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  function automatic logic [7:0] pat(input logic [8:0] a);
    return a[7:0] ^ {7'h00, a[8]} ^ 8'h3c;
  endfunction

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One single word transfer; entered just after a rising edge.
  task automatic bus(input bit w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK("hrdata", e, q)
    `CHK("hresp", HRESP_OKAY, hresp)
  endtask

  // Flow strobe k for one cycle, with the model of counter and stack.
  task automatic flow(input int k, input logic [10:0] t);
    fl <= 5'h01 << k;
    flow_target <= t;
    @(posedge hclk);
    fl <= 5'h00;
    if (k > 2)
    begin
      stk[sp] = (k == 3) ? m_pc + 1 : m_pc;
      sp = (sp + 1) % 8;
    end
    case (k)
      0: m_pc = m_pc + 1;
      1: m_pc = stk[(sp + 7) % 8];
      2, 3: m_pc = (lat / 8) * 2048 + t;
      default: m_pc = VECTOR_DEFAULT;
    endcase
    if (k == 1)
      sp = (sp + 7) % 8;
    m_pc = m_pc % 8192;
    @(posedge hclk);
    `CHK("pc", 13'(m_pc), pc)
  endtask

  // One data access with the expected resolution.
  task automatic acc(input bit w, input logic [8:0] a);
    int ea;
    bit s;
    ea = (a[6:0] == 7'h00) ? bank * 256 + ptr : a;
    s = a[6:0] == 7'h00 && ptr % 128 == 0;
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= a[7:0] ^ 8'ha5;
    @(posedge hclk);
    acc_valid <= 1'b0;
    @(posedge hclk);
    `CHK("strobes", {!s && !w, !s && w}, {data_rd, data_wr})
    if (!s) `CHK("data_addr", 9'(ea), data_addr)
    if (!s && w) `CHK("data_wdata", a[7:0] ^ 8'ha5, data_wdata)
    @(posedge hclk);
    `CHK("rdata_valid", 1'(!w), acc_rdata_valid)
    if (!w) `CHK("acc_rdata", s ? READ_ZERO : pat(9'(ea)), acc_rdata)
  endtask

  // Main sequence.
  initial
  begin
    logic [31:0] q;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(OFF_COUNTER_LOW, 32'h0);
    rdc(OFF_HIGH_LATCH, 32'h0);
    rdc(8'h40, 32'h0);
    lat = xs() % 32;
    bus(1'b1, OFF_HIGH_LATCH, 32'(lat), q);
    bus(1'b1, OFF_COUNTER_LOW, 32'h9c, q);
    m_pc = lat * 256 + 'h9c;
    rdc(OFF_COUNTER_LOW, 32'h9c);
    `CHK("pc", 13'(m_pc), pc)
    for (int i = 0; i < 9; i++)
      flow(3, 11'(xs()));
    for (int i = 0; i < 9; i++)
      flow(1, 11'h000);
    rdc(OFF_HIGH_LATCH, 32'(lat));
    flow(2, 11'(xs()));
    flow(0, 11'h000);
    flow(4, 11'h000);
    flow(1, 11'h000);
    fl <= 5'h08;
    @(posedge hclk);
    fl <= 5'h02;
    @(posedge hclk);
    fl <= 5'h00;
    m_pc = (m_pc + 1) % 8192;
    @(posedge hclk);
    `CHK("pc", 13'(m_pc), pc)
    bus(1'b1, OFF_POINTER, 32'h47, q);
    bus(1'b1, OFF_STATUS, 32'h80, q);
    ptr = 'h47;
    bank = 1;
    rdc(OFF_STATUS, 32'h80);
    for (int i = 0; i < 6; i++)
      acc(1'(i % 2), 9'(xs()) | 9'h001);
    acc(1'b0, 9'h080);
    acc(1'b1, 9'h000);
    rdc(OFF_EFF_ADDR, 32'h147);
    bus(1'b1, OFF_POINTER, 32'h80, q);
    ptr = 'h80;
    acc(1'b0, 9'h100);
    acc(1'b1, 9'h000);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("pc", 13'h0000, pc)
    rdc(OFF_POINTER, 32'h0);
    tally_and_finish();
  end
endmodule
